//--- wdw_pkg.sv
/*
 * constants and types shared by the windowed down-count watchdog
 * assumes a single 125 MHz clock (the divided oscillator clock)
 */
package wdw_pkg;

    // ****************************************************************
    // control register layout and reset value
    // ****************************************************************
    localparam int            CNT_W         = 7;
    localparam int            ACT_BIT_POS   = 7;
    localparam int            TOP_BIT_POS   = 6;
    localparam logic [7:0]    CTRL_RESET    = 8'h7F;
    localparam logic [6:0]    ROLL_VALUE    = 7'h40;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int            CLK_PERIOD_PS = 8000;
    localparam int            TICK_CYCLES   = 16384;
    localparam int            PHASE_STEP    = 64;
    localparam int            RST_PULSE_NS  = 30000;    // 30 us reset pulse
    localparam int            RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
    localparam int            STAB_SHORT    = 256;
    localparam int            STAB_LONG     = 4096;
    localparam int            PULSE_W       = 12;
    localparam int            STAB_W        = 13;

    // prescaler phase offsets, one per timebase selection
    localparam logic [5:0]    TB_PHASE [4]  = '{6'h3B, 6'h35, 6'h23, 6'h36};

    // ****************************************************************
    // operating states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_STAB      = 3'h0,
        ST_RUN       = 3'h1,
        ST_HALT_ONE  = 3'h3,
        ST_HALT_FRZ  = 3'h2,
        ST_ACT_HALT  = 3'h6,
        ST_RESETTING = 3'h5
    } wdw_state_t;

endpackage : wdw_pkg

//--- wdw_prescaler.sv
/*
 * free-running tick prescaler for the watchdog counter
 * assumes clk is the divided oscillator clock; no software access
 */
`timescale 1ns/10ps
module wdw_prescaler #(
    parameter int TICK_CYCLES = wdw_pkg::TICK_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] phaseSel,
    output logic            tick
);
    import wdw_pkg::*;

    localparam int W = $clog2(TICK_CYCLES);

    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;
    logic         tick_ff;
    logic         nxt_tick;
    logic [W-1:0] phase;

    // ****************************************************************
    // phase offset and wrap count
    // ****************************************************************
    // offset follows the timebase selection; never cleared by writes
    always_comb begin
        phase     = W'((int'(TB_PHASE[phaseSel]) * PHASE_STEP) % TICK_CYCLES);
        nxt_count = (count_ff == W'(TICK_CYCLES - 1)) ? '0 : count_ff + 1'b1;
        nxt_tick  = (count_ff == phase);
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
            tick_ff  <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tick_ff  <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule // wdw_prescaler

//--- wdw_top.sv
/*
 * windowed down-count watchdog: control register, counter, halt handling
 * and reset pulse generation
 * assumes all inputs synchronous to clk; option inputs static after reset
 */
// Summary of operation
// - counter decrements once every 16384 clock cycles
// - counting continues while the watchdog is not active
// - active and counter passing 40h to 3Fh drives reset low 30 us
// - six low bits give 64 timeout steps
// - a register write never realigns the prescaler
// - inactive after reset, once active stays active until reset
// - writing activation set with top bit clear in ST_RUN resets at once
// - halt while active, with oscillatorIrqEnable clear and optHaltReset set, produces a reset instead of halting
// - halt reset selected by a nonvolatile option input
// - hardware watchdog option runs without software activation
// - prescaler phase follows the timebase selection
// - register resets to 7Fh, activation cleared only by reset
// - hardware option makes watchdog always active, ignores bit
// - plain halt decrements once then freezes until external interrupt or reset
// - active halt freezes; resumes on oscillator or external interrupt without stabilisation
`timescale 1ns/10ps
module wdw_top #(
    parameter int TICK_CYCLES = wdw_pkg::TICK_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] ctrlRegRd,
    input  wire logic       optHwWatchdog,
    input  wire logic       optHaltReset,
    input  wire logic       optLongStab,
    input  wire logic [1:0] rtcTimebaseSelect,
    input  wire logic       oscillatorIrqEnable,
    input  wire logic       haltExec,
    input  wire logic       oscIrq,
    input  wire logic       extIrq,
    output logic            resetPinOut,
    output logic            resetPinOe_n
);
    import wdw_pkg::*;

    wdw_state_t         state_ff, nxt_state;
    logic [CNT_W-1:0]   count_ff, nxt_count;
    logic               actBit_ff, nxt_actBit;
    logic [PULSE_W-1:0] pulse_ff, nxt_pulse;
    logic [STAB_W-1:0]  stab_ff, nxt_stab;
    logic               pinOe_n_ff;
    logic               tick;
    logic               active;
    logic               wrActive;
    logic [STAB_W-1:0]  stabLast;

    // ****************************************************************
    // tick prescaler
    // ****************************************************************
    wdw_prescaler #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_prescaler (
        .clk      (clk),
        .rst_n    (rst_n),
        .phaseSel (rtcTimebaseSelect),
        .tick     (tick)
    );

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    assign active   = actBit_ff | optHwWatchdog;
    assign wrActive = active | wrData[ACT_BIT_POS];
    assign stabLast = optLongStab ? STAB_W'(STAB_LONG - 1) : STAB_W'(STAB_SHORT - 1);

    // counter, activation, halt sequencing and reset pulse
    always_comb begin
        nxt_state  = state_ff;
        nxt_count  = count_ff;
        nxt_actBit = actBit_ff;
        nxt_pulse  = pulse_ff;
        nxt_stab   = stab_ff;
        unique case (state_ff)
            ST_STAB: begin
                nxt_stab = stab_ff + 1'b1;
                if (stab_ff == stabLast) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (tick) begin
                    nxt_count = count_ff - 1'b1;
                end
                if (wrEn && wrActive && !wrData[TOP_BIT_POS]) begin
                    nxt_state = ST_RESETTING;
                end else if (!wrEn && tick && active && count_ff == ROLL_VALUE) begin
                    nxt_state = ST_RESETTING;
                end else if (haltExec) begin
                    if (oscillatorIrqEnable) begin
                        nxt_state = ST_ACT_HALT;
                    end else if (active && optHaltReset) begin
                        nxt_state = ST_RESETTING;
                    end else begin
                        nxt_state = ST_HALT_ONE;
                    end
                end
            end
            ST_HALT_ONE: begin
                if (extIrq) begin
                    nxt_state = ST_STAB;
                end else if (tick) begin
                    nxt_count = count_ff - 1'b1;
                    nxt_state = ST_HALT_FRZ;
                end
            end
            ST_HALT_FRZ: begin
                if (extIrq) begin
                    nxt_state = ST_STAB;
                end
            end
            ST_ACT_HALT: begin
                if (oscIrq || extIrq) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RESETTING: begin
                if (tick) begin
                    nxt_count = count_ff - 1'b1;
                end
                nxt_pulse = pulse_ff + 1'b1;
                if (pulse_ff == PULSE_W'(RST_PULSE_CYC - 1)) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
        // a write reloads the counter; activation can only be set
        if (wrEn) begin
            nxt_count  = wrData[CNT_W-1:0];
            nxt_actBit = actBit_ff | wrData[ACT_BIT_POS];
        end
        if (nxt_state == ST_STAB && state_ff != ST_STAB) begin
            nxt_stab = '0;
        end
        if (nxt_state == ST_RESETTING && state_ff != ST_RESETTING) begin
            nxt_pulse = '0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // stabilisation wait also follows every reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= ST_STAB;
            count_ff   <= CTRL_RESET[CNT_W-1:0];
            actBit_ff  <= CTRL_RESET[ACT_BIT_POS];
            pulse_ff   <= '0;
            stab_ff    <= '0;
            pinOe_n_ff <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            count_ff   <= nxt_count;
            actBit_ff  <= nxt_actBit;
            pulse_ff   <= nxt_pulse;
            stab_ff    <= nxt_stab;
            pinOe_n_ff <= (nxt_state != ST_RESETTING);
        end
    end

    // read view of the control register
    assign ctrlRegRd    = {actBit_ff, count_ff};
    assign resetPinOut  = 1'b0;
    assign resetPinOe_n = pinOe_n_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    act_sticky_a: assert property (actBit_ff |=> actBit_ff)
        else $error("activation bit cleared without reset");
    act_set_only_a: assert property (!actBit_ff && !(wrEn && wrData[7]) |=> !actBit_ff)
        else $error("activation bit set without a write");
    count_dec_a: assert property (state_ff == ST_RUN && tick && !wrEn
        |=> count_ff == $past(count_ff) - 7'h01)
        else $error("counter did not decrement on tick");
    count_hold_a: assert property (state_ff == ST_RUN && !tick && !wrEn
        |=> $stable(count_ff))
        else $error("counter moved without tick");
    rollover_rst_a: assert property (state_ff == ST_RUN && tick && active && !wrEn
        && !haltExec && count_ff == 7'h40 |=> !resetPinOe_n && pulse_ff == '0)
        else $error("rollover did not start reset pulse");
    pulse_len_a: assert property (state_ff == ST_RESETTING && pulse_ff == 12'hEA5
        |=> resetPinOe_n ##1 resetPinOe_n)
        else $error("reset pulse length wrong");
    pulse_cont_a: assert property (state_ff == ST_RESETTING && pulse_ff < 12'hEA5
        |=> !resetPinOe_n)
        else $error("reset pulse ended early");
    wr_load_a: assert property (wrEn |=> count_ff == $past(wrData[6:0]))
        else $error("write did not load counter");
    sw_reset_a: assert property (state_ff == ST_RUN && wrEn && wrData[7] && !wrData[6]
        |=> state_ff == ST_RESETTING)
        else $error("software reset not taken");
    halt_reset_a: assert property (state_ff == ST_RUN && haltExec && active
        && !oscillatorIrqEnable && optHaltReset && !wrEn |=> !resetPinOe_n)
        else $error("halt while active did not reset");
    halt_freeze_a: assert property (state_ff == ST_HALT_FRZ && !extIrq && !wrEn
        |=> $stable(count_ff) && resetPinOe_n)
        else $error("frozen halt counter moved");
    act_halt_a: assert property (state_ff == ST_ACT_HALT && !wrEn
        |=> $stable(count_ff))
        else $error("counter moved in active halt");
    hw_mode_a: assert property (optHwWatchdog && !actBit_ff && state_ff == ST_RUN && tick
        && !wrEn && !haltExec && count_ff == 7'h40 |=> state_ff == ST_RESETTING)
        else $error("hardware watchdog did not fire");

    rollover_c: cover property (state_ff == ST_RUN && tick && active && count_ff == 7'h40);
    sw_reset_c: cover property (state_ff == ST_RUN && wrEn && wrData[7:6] == 2'b10);
    halt_wake_c: cover property (state_ff == ST_HALT_FRZ ##1 state_ff == ST_STAB);
    act_halt_c: cover property (state_ff == ST_ACT_HALT ##1 state_ff == ST_RUN);

endmodule // wdw_top

//--- wdw_tb.sv
/*
 * self-checking bench for the windowed down-count watchdog top
 * assumes wdw_pkg and wdw_top compiled first; short tick of 64 cycles
 */
`timescale 1ns/10ps
module testbench;
    import wdw_pkg::*;
    // ********************************
    // signals and design instance
    // ********************************
    localparam int TICK = 64;
    logic       clk, rst_n, wrEn, haltExec, oscIrq, extIrq;
    logic [7:0] wrData, ctrlRegRd;
    logic       optHw, optHalt, optLong, oscillator_irq_enable, resetPinOut, resetPinOe_n;
    logic [7:0] rowIn  [6] = '{8'h7F, 8'h3F, 8'hC5, 8'h45, 8'h00, 8'hFF};
    logic [7:0] rowExp [6] = '{8'h7F, 8'h3F, 8'hC5, 8'hC5, 8'h80, 8'hFF};
    int         error_cnt  = 0;
    int         n_compared = 0;
    int         cycles     = 0;
    int         n;
    wdw_top #(.TICK_CYCLES(TICK)) uut (
        .clk(clk), .rst_n(rst_n), .wrEn(wrEn), .wrData(wrData), .ctrlRegRd(ctrlRegRd),
        .optHwWatchdog(optHw), .optHaltReset(optHalt), .optLongStab(optLong),
        .rtcTimebaseSelect(2'h0), .oscillatorIrqEnable(oscillator_irq_enable), .haltExec(haltExec),
        .oscIrq(oscIrq), .extIrq(extIrq), .resetPinOut(resetPinOut),
        .resetPinOe_n(resetPinOe_n));
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // ********************************
    // helper tasks
    // ********************************
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic cmpI(input int got, input int exp);
        cmp8(got[7:0], exp[7:0]);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic stab();
        repeat (STAB_SHORT + 10) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] d);
        wrEn   = 1'b1;
        wrData = d;
        @(negedge clk);
        wrEn   = 1'b0;
    endtask
    task automatic pulse_halt();
        haltExec = 1'b1;
        @(negedge clk);
        haltExec = 1'b0;
    endtask
    // waits for one counter step and checks it went down by one
    task automatic wait_dec(output int k);
        logic [7:0] old;
        old = ctrlRegRd;
        k   = 0;
        while (ctrlRegRd === old && k < 2 * TICK + 8) begin
            @(negedge clk);
            k++;
        end
        cmp8(ctrlRegRd, old - 8'h01);
    endtask
    task automatic wait_low(input int lim);
        int k;
        k = 0;
        while (resetPinOe_n !== 1'b0 && k < lim) begin
            @(negedge clk);
            k++;
        end
        cmp1(resetPinOe_n, 1'b0);
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        rst_n    = 1'b0;
        wrEn     = 1'b0;
        wrData   = 8'h00;
        haltExec = 1'b0;
        oscIrq   = 1'b0;
        extIrq   = 1'b0;
        optHw    = 1'b0;
        optHalt  = 1'b0;
        optLong  = 1'b0;
        oscillator_irq_enable      = 1'b0;
        do_reset();
        cmp8(ctrlRegRd, 8'h7F);
        // table of writes during stabilisation, no reset may fire
        for (int i = 0; i < 6; i++) begin
            wr(rowIn[i]);
            cmp8(ctrlRegRd, rowExp[i]);
            cmp1(resetPinOe_n, 1'b1);
            // idle cycle so the strobe is not raised where it was just lowered
            @(negedge clk);
        end
        do_reset();
        cmp8(ctrlRegRd, 8'h7F);
        stab();
        // tick spacing, and a write that must not realign it
        wait_dec(n);
        wait_dec(n);
        cmpI(n, TICK);
        repeat (20) @(negedge clk);
        wr(8'h70);
        wait_dec(n);
        cmpI(n, TICK - 21);
        // inactive counter passes 40h to 3Fh silently
        wr(8'h41);
        wait_dec(n);
        wait_dec(n);
        cmp1(resetPinOe_n, 1'b1);
        // active timeout after two steps of delay, reload in range
        wr(8'hC2);
        wait_dec(n);
        cmp1(resetPinOe_n, 1'b1);
        wait_dec(n);
        cmp1(resetPinOe_n, 1'b1);
        wait_low(TICK + 8);
        cmp1(resetPinOut, 1'b0);
        cmp8(ctrlRegRd, 8'hBF);
        n = 0;
        while (resetPinOe_n === 1'b0) begin
            @(negedge clk);
            n++;
        end
        cmpI(n, RST_PULSE_CYC);
        // software reset with top bit clear
        do_reset();
        stab();
        wr(8'h80);
        cmp1(resetPinOe_n, 1'b0);
        // halt while active with halt-reset option
        do_reset();
        stab();
        wr(8'hFF);
        optHalt = 1'b1;
        pulse_halt();
        cmp1(resetPinOe_n, 1'b0);
        // plain halt: one step then frozen, resumes after external interrupt
        optHalt = 1'b0;
        do_reset();
        stab();
        wr(8'hC1);
        pulse_halt();
        repeat (3 * TICK) @(negedge clk);
        cmp8(ctrlRegRd, 8'hC0);
        cmp1(resetPinOe_n, 1'b1);
        extIrq = 1'b1;
        @(negedge clk);
        extIrq = 1'b0;
        repeat (STAB_SHORT - 8) @(negedge clk);
        cmp8(ctrlRegRd, 8'hC0);
        wait_dec(n);
        // active halt: frozen until oscillator interrupt
        do_reset();
        stab();
        wr(8'hFF);
        oscillator_irq_enable = 1'b1;
        pulse_halt();
        repeat (3 * TICK) @(negedge clk);
        cmp8(ctrlRegRd, 8'hFF);
        cmp1(resetPinOe_n, 1'b1);
        oscIrq = 1'b1;
        @(negedge clk);
        oscIrq = 1'b0;
        wait_dec(n);
        oscillator_irq_enable = 1'b0;
        // hardware option, long stabilisation: frozen 4096 cycles, then times out
        optHw   = 1'b1;
        optLong = 1'b1;
        do_reset();
        repeat (STAB_LONG - 8) @(negedge clk);
        cmp8(ctrlRegRd, 8'h7F);
        repeat (18) @(negedge clk);
        wr(8'h41);
        wait_low(3 * TICK);
        close_out();
    end
endmodule // testbench
